/* core/sspi2c_core.v */
// Added by the designer: the address map and the plain strobed port.
`include "sspi2c_map.vh"
`default_nettype none
module sspi2c_core (
	input wire clk,
	input wire arst_n,
	input wire [2:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire [1:0] port_b_direction,
	output wire port_irq_flag,
	output wire pins_to_port
);
	// ***********************************************
	// Reset and pin synchronisers
	// ***********************************************
	reg [1:0] rst_q;
	wire rst_n = rst_q[1];
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rst_q <= 2'b00;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	reg [1:0] scl_s_q, sda_s_q;
	reg scl_p_q, sda_p_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s_q <= 2'b11;
			sda_s_q <= 2'b11;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_in};
			sda_s_q <= {sda_s_q[0], sda_in};
			scl_p_q <= scl_s_q[1];
			sda_p_q <= sda_s_q[1];
		end
	end
	wire scl = scl_s_q[1];
	wire sda = sda_s_q[1];
	wire scl_rise = scl & ~scl_p_q;
	wire scl_fall = ~scl & scl_p_q;
	wire bus_start = scl & scl_p_q & ~sda & sda_p_q;
	wire bus_stop = scl & scl_p_q & sda & ~sda_p_q;
	// ***********************************************
	// Registers
	// ***********************************************
	reg [7:0] ctrl1_q, ctrl2_q, buf_q, adr_q, sr_q;
	reg bf_q, ua_q, rw_q, s_q, p_q, da_q, irq_q;
	wire en = ctrl1_q[`SSPI2C_C1_EN];
	wire [3:0] mode = ctrl1_q[3:0];
	wire is_hwm = (mode == `SSPI2C_M_HWM);
	wire is_fwm = (mode == `SSPI2C_M_FWM);
	wire is_s10 = (mode == `SSPI2C_M_S10I) | (mode == `SSPI2C_M_S10);
	wire is_slv = is_s10 | (mode == `SSPI2C_M_S7I) | (mode == `SSPI2C_M_S7);
	wire ss_irq = (mode == `SSPI2C_M_S10I) | (mode == `SSPI2C_M_S7I);
	wire active = en & (is_slv | is_hwm | is_fwm);
	wire [4:0] cmds = ctrl2_q[4:0];
	wire m_idle = ~(rw_q & is_hwm) & (cmds == 5'h00);
	// ***********************************************
	// Master engine
	// ***********************************************
	localparam MS_IDLE = 3'd0, MS_START = 3'd1, MS_STOP = 3'd2, MS_TX = 3'd3;
	localparam MS_RX = 3'd4, MS_ACK = 3'd5, MS_RST = 3'd6;
	reg [2:0] ms_q;
	reg [1:0] ph_q;
	reg [3:0] bit_q;
	reg m_scl_q, m_sda_q;
	wire tick;
	sspi2c_brg u_brg (
		.clk(clk),
		.rst_n(rst_n),
		.run(ms_q != MS_IDLE),
		.reload(adr_q[6:0]),
		.tick(tick)
	);
	// ***********************************************
	// Slave engine
	// ***********************************************
	localparam SS_IDLE = 2'd0, SS_RX = 2'd1, SS_ACK = 2'd2, SS_TX = 2'd3;
	reg [1:0] ss_q;
	reg [3:0] sb_q;
	reg matched_q, ack_drv_q, tx_drv_q, hold_q, txm_q, hi_q, nack_q;
	wire gc_hit = ctrl2_q[`SSPI2C_C2_GC] & (sr_q == 8'h00);
	wire a7_hit = (sr_q[7:1] == adr_q[7:1]);
	wire a10_hi = (sr_q[7:3] == 5'h1e);
	wire full = bf_q | ctrl1_q[`SSPI2C_C1_OV];
	wire buf_wr = wr & (addr == `SSPI2C_OFF_BUF);
	wire buf_ok = is_slv ? ~(tx_drv_q & bf_q) : (m_idle & ms_q == MS_IDLE);
	// Hardware sets win over software clears below
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_q <= `SSPI2C_RST_CTRL1;
			ctrl2_q <= `SSPI2C_RST_CTRL2;
			buf_q <= 8'h00; adr_q <= 8'h00; sr_q <= 8'h00;
			bf_q <= 1'b0; ua_q <= 1'b0; rw_q <= 1'b0; s_q <= 1'b0;
			p_q <= 1'b0; da_q <= 1'b0; irq_q <= 1'b0;
			ms_q <= MS_IDLE; ph_q <= 2'd0; bit_q <= 4'd0;
			m_scl_q <= 1'b1; m_sda_q <= 1'b1;
			ss_q <= SS_IDLE; sb_q <= 4'd0; matched_q <= 1'b0;
			ack_drv_q <= 1'b0; tx_drv_q <= 1'b0; hold_q <= 1'b0;
			txm_q <= 1'b0; hi_q <= 1'b0; nack_q <= 1'b0;
		end else begin
			// Software side
			if (wr && addr == `SSPI2C_OFF_CTRL1)
				ctrl1_q <= wdata;
			if (wr && addr == `SSPI2C_OFF_CTRL2) begin
				ctrl2_q[7:5] <= {wdata[7], ctrl2_q[6], wdata[5]};
				if (m_idle || !is_hwm)
					ctrl2_q[4:0] <= wdata[4:0];
			end
			if (wr && addr == `SSPI2C_OFF_ADDR) begin
				adr_q <= wdata;
				ua_q <= 1'b0;
				hold_q <= 1'b0;
			end
			if (wr && addr == `SSPI2C_OFF_IRQ)
				irq_q <= wdata[0];
			if (rd && addr == `SSPI2C_OFF_BUF)
				bf_q <= 1'b0;
			if (buf_wr) begin
				if (buf_ok) begin
					buf_q <= wdata;
					sr_q <= wdata;
					bf_q <= 1'b1;
					if (!is_slv && is_hwm) begin
						ms_q <= MS_TX; bit_q <= 4'd0; ph_q <= 2'd0; rw_q <= 1'b1;
					end
				end else
					ctrl1_q[`SSPI2C_C1_WRITE_COLLISION_FLAG] <= 1'b1;
			end
			// Master sequencing, four phases per bit
			if (!active || !is_hwm) begin
				ms_q <= MS_IDLE; m_scl_q <= 1'b1; m_sda_q <= 1'b1;
				// Pending commands would fire again on re-enable
				if (!en && is_hwm)
					ctrl2_q[4:0] <= 5'h00;
			end else if (ms_q == MS_IDLE) begin
				ph_q <= 2'd0; bit_q <= 4'd0;
				if (cmds[`SSPI2C_C2_SEN]) ms_q <= MS_START;
				else if (cmds[`SSPI2C_C2_RST]) ms_q <= MS_RST;
				else if (cmds[`SSPI2C_C2_STP]) ms_q <= MS_STOP;
				else if (cmds[`SSPI2C_C2_RCE]) ms_q <= MS_RX;
				else if (cmds[`SSPI2C_C2_AKE]) ms_q <= MS_ACK;
			end else if (tick) begin
				ph_q <= ph_q + 2'd1;
				case (ms_q)
				MS_START, MS_RST: begin
					if (ph_q == 2'd0) begin m_sda_q <= 1'b1; m_scl_q <= 1'b1; end
					if (ph_q == 2'd1) m_sda_q <= 1'b0;
					if (ph_q == 2'd2) m_scl_q <= 1'b0;
					if (ph_q == 2'd3) begin
						ms_q <= MS_IDLE;
						ctrl2_q[`SSPI2C_C2_SEN] <= 1'b0;
						ctrl2_q[`SSPI2C_C2_RST] <= 1'b0;
						irq_q <= 1'b1;
					end
				end
				MS_STOP: begin
					if (ph_q == 2'd0) begin m_sda_q <= 1'b0; m_scl_q <= 1'b0; end
					if (ph_q == 2'd1) m_scl_q <= 1'b1;
					if (ph_q == 2'd2) m_sda_q <= 1'b1;
					if (ph_q == 2'd3) begin
						ms_q <= MS_IDLE; ctrl2_q[`SSPI2C_C2_STP] <= 1'b0; irq_q <= 1'b1;
					end
				end
				MS_TX, MS_RX, MS_ACK: begin
					if (ph_q == 2'd0) begin
						m_scl_q <= 1'b0;
						if (ms_q == MS_TX) m_sda_q <= (bit_q == 4'd8) ? 1'b1 : sr_q[7];
						else if (ms_q == MS_RX) m_sda_q <= 1'b1;
						else m_sda_q <= ctrl2_q[`SSPI2C_C2_AKD];
					end
					if (ph_q == 2'd1) m_scl_q <= 1'b1;
					if (ph_q == 2'd2) begin
						if (ms_q == MS_TX && bit_q == 4'd8)
							ctrl2_q[`SSPI2C_C2_AKS] <= sda;
						else if (ms_q == MS_TX) begin
							sr_q <= {sr_q[6:0], 1'b0};
							if (bit_q == 4'd7) bf_q <= 1'b0;
						end else if (ms_q == MS_RX)
							sr_q <= {sr_q[6:0], sda};
					end
					if (ph_q == 2'd3) begin
						m_scl_q <= 1'b0;
						bit_q <= bit_q + 4'd1;
						if (ms_q == MS_ACK) begin
							ms_q <= MS_IDLE; ctrl2_q[`SSPI2C_C2_AKE] <= 1'b0; irq_q <= 1'b1;
						end else if (ms_q == MS_TX && bit_q == 4'd8) begin
							ms_q <= MS_IDLE; rw_q <= 1'b0; irq_q <= 1'b1;
						end else if (ms_q == MS_RX && bit_q == 4'd7) begin
							ms_q <= MS_IDLE; ctrl2_q[`SSPI2C_C2_RCE] <= 1'b0; irq_q <= 1'b1;
							if (bf_q) ctrl1_q[`SSPI2C_C1_OV] <= 1'b1;
							else begin buf_q <= sr_q; bf_q <= 1'b1; end
						end
					end
				end
				default: ms_q <= MS_IDLE;
				endcase
			end
			// Slave sequencing
			if (!active || !is_slv) begin
				ss_q <= SS_IDLE; ack_drv_q <= 1'b0; tx_drv_q <= 1'b0; hold_q <= 1'b0;
				matched_q <= 1'b0; hi_q <= 1'b0;
				if (!en) begin s_q <= 1'b0; p_q <= 1'b0; end
			end else if (bus_start || bus_stop) begin
				ss_q <= SS_RX; sb_q <= 4'd0; ack_drv_q <= 1'b0; tx_drv_q <= 1'b0;
				s_q <= bus_start; p_q <= bus_stop;
				if (bus_stop) begin ss_q <= SS_IDLE; matched_q <= 1'b0; hi_q <= 1'b0; end
				rw_q <= 1'b0;
				if (ss_irq) irq_q <= 1'b1;
			end else begin
				case (ss_q)
				SS_RX: if (scl_rise) begin
					sr_q <= {sr_q[6:0], sda};
					sb_q <= sb_q + 4'd1;
				end else if (scl_fall && sb_q == 4'd8) begin
					ss_q <= SS_ACK; nack_q <= 1'b1;
					if (!matched_q) begin
						if (gc_hit || (!is_s10 && a7_hit) || (is_s10 && a10_hi && sr_q[2:1] == adr_q[2:1])
							|| (is_s10 && hi_q)) begin
							if (!full) begin
								ack_drv_q <= 1'b1; buf_q <= sr_q; bf_q <= 1'b1; nack_q <= 1'b0;
							end else ctrl1_q[`SSPI2C_C1_OV] <= ctrl1_q[`SSPI2C_C1_OV] | bf_q;
							irq_q <= 1'b1;
							da_q <= 1'b0;
							if (is_s10 && !hi_q && !gc_hit && !sr_q[0]) begin
								hi_q <= 1'b1; ua_q <= 1'b1; hold_q <= 1'b1;
							end else begin
								matched_q <= 1'b1; rw_q <= sr_q[0]; txm_q <= sr_q[0];
								if (is_s10 && !sr_q[0] && hi_q) begin ua_q <= 1'b1; hold_q <= 1'b1; end
							end
						end else ss_q <= SS_IDLE;
					end else begin
						da_q <= 1'b1; irq_q <= 1'b1;
						if (!full) begin ack_drv_q <= 1'b1; buf_q <= sr_q; bf_q <= 1'b1; nack_q <= 1'b0; end
						else ctrl1_q[`SSPI2C_C1_OV] <= 1'b1;
					end
				end
				SS_ACK: if (scl_fall) begin
					ack_drv_q <= 1'b0; sb_q <= 4'd0;
					if (txm_q && matched_q) begin
						ss_q <= SS_TX; tx_drv_q <= 1'b1; bf_q <= 1'b0;
						ctrl1_q[`SSPI2C_C1_CKR] <= 1'b0;
					end else begin
						ss_q <= SS_RX;
						if (ctrl2_q[`SSPI2C_C2_SEN] && bf_q) ctrl1_q[`SSPI2C_C1_CKR] <= 1'b0;
					end
				end
				SS_TX: if (scl_rise) begin
					sb_q <= sb_q + 4'd1;
					if (sb_q == 4'd8) begin
						if (sda) begin ss_q <= SS_IDLE; rw_q <= 1'b0; matched_q <= 1'b0; end
						else begin tx_drv_q <= 1'b0; ss_q <= SS_ACK; end
						irq_q <= 1'b1;
					end
				end else if (scl_fall && sb_q != 4'd0 && sb_q != 4'd8) begin
					sr_q <= {sr_q[6:0], 1'b1};
					if (sb_q == 4'd7) bf_q <= 1'b0;
				end else if (scl_fall && sb_q == 4'd8)
					tx_drv_q <= 1'b0;
				default: ;
				endcase
			end
			if (buf_wr && is_slv && buf_ok)
				bf_q <= 1'b1;
		end
	end
	// ***********************************************
	// Pins and register reads
	// ***********************************************
	wire pins_in = port_b_direction == 2'b11;
	assign pins_to_port = en;
	wire s_stretch = hold_q | ~ctrl1_q[`SSPI2C_C1_CKR];
	wire drv_scl = is_hwm ? ~m_scl_q : (is_slv & s_stretch & (ss_q != SS_IDLE));
	wire s_sda_low = ack_drv_q | (tx_drv_q & ~sr_q[7]);
	wire drv_sda = is_hwm ? ~m_sda_q : (is_slv & s_sda_low);
	// Open-drain: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = active & pins_in & drv_scl;
	assign sda_oe = active & pins_in & drv_sda;
	assign port_irq_flag = irq_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (rd) begin
			case (addr)
			`SSPI2C_OFF_STATUS: rdata <= {2'b00, da_q, p_q, s_q, rw_q, ua_q, bf_q};
			`SSPI2C_OFF_CTRL1: rdata <= ctrl1_q;
			`SSPI2C_OFF_CTRL2: rdata <= ctrl2_q;
			`SSPI2C_OFF_BUF: rdata <= buf_q;
			`SSPI2C_OFF_ADDR: rdata <= adr_q;
			`SSPI2C_OFF_IRQ: rdata <= {7'h00, irq_q};
			default: rdata <= 8'h00;
			endcase
		end
	end
endmodule // sspi2c_core
`default_nettype wire

/* core/sspi2c_map.vh */
`ifndef SSPI2C_MAP_VH
`define SSPI2C_MAP_VH
// ***********************************************
// Register offsets (plain port addressing)
// ***********************************************
`define SSPI2C_OFF_STATUS 3'h0
`define SSPI2C_OFF_CTRL1 3'h1
`define SSPI2C_OFF_CTRL2 3'h2
`define SSPI2C_OFF_BUF 3'h3
`define SSPI2C_OFF_ADDR 3'h4
`define SSPI2C_OFF_IRQ 3'h5
// ***********************************************
// Field positions
// ***********************************************
`define SSPI2C_ST_BF 0
`define SSPI2C_ST_UA 1
`define SSPI2C_ST_RW 2
`define SSPI2C_ST_S 3
`define SSPI2C_ST_P 4
`define SSPI2C_ST_DA 5
`define SSPI2C_C1_WRITE_COLLISION_FLAG 7
`define SSPI2C_C1_OV 6
`define SSPI2C_C1_EN 5
`define SSPI2C_C1_CKR 4
`define SSPI2C_C2_GC 7
`define SSPI2C_C2_AKS 6
`define SSPI2C_C2_AKD 5
`define SSPI2C_C2_AKE 4
`define SSPI2C_C2_RCE 3
`define SSPI2C_C2_STP 2
`define SSPI2C_C2_RST 1
`define SSPI2C_C2_SEN 0
// ***********************************************
// Reset values and mode codes
// ***********************************************
`define SSPI2C_RST_STATUS 8'h00
`define SSPI2C_RST_CTRL1 8'h00
`define SSPI2C_RST_CTRL2 8'h00
`define SSPI2C_M_S10I 4'hf
`define SSPI2C_M_S7I 4'he
`define SSPI2C_M_FWM 4'hb
`define SSPI2C_M_HWM 4'h8
`define SSPI2C_M_S10 4'h7
`define SSPI2C_M_S7 4'h6
`endif

/* core/sspi2c_brg.v */
`default_nettype none
// ***********************************************
// Baud generator: tick every reload+1 clocks
// ***********************************************
module sspi2c_brg (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire [6:0] reload,
	output reg tick
);
	reg [6:0] cnt_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 7'h00;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_q <= reload;
			tick <= 1'b0;
		end else if (cnt_q == 7'h00) begin
			cnt_q <= reload;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q - 7'h01;
			tick <= 1'b0;
		end
	end
endmodule // sspi2c_brg
`default_nettype wire

/* verif/sspi2c_chk_asserts.sv */
`default_nettype none
module sspi2c_chk (
	input wire clk,
	input wire arst_n,
	input wire [2:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	input wire scl_out,
	input wire scl_oe,
	input wire sda_out,
	input wire sda_oe,
	input wire [1:0] port_b_direction,
	input wire port_irq_flag,
	input wire pins_to_port
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ********
	// Mode tracking
	// ********
	logic hwm_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			hwm_q <= 1'b0;
		else if (wr && addr == 3'h1)
			hwm_q <= wdata[3:0] == 4'h8;
	end
	// Only a start from a quiet bus; a refused one still arms this while neither line is driven
	sequence start_cmd_s;
		wr && addr == 3'h2 && wdata[0] && hwm_q && pins_to_port && !scl_oe && !sda_oe;
	endsequence
	sequence start_cond_s;
		##[1:600] (($rose(sda_oe) && !scl_oe) || !pins_to_port);
	endsequence
	dir_needed_a: assert property (
		scl_oe || sda_oe |-> port_b_direction == 2'b11) else $error("drive without input dir");
	release_off_a: assert property (
		!pins_to_port |-> !scl_oe && !sda_oe) else $error("lines driven while off");
	open_drain_a: assert property (
		(scl_oe |-> !scl_out) and (sda_oe |-> !sda_out)) else $error("line driven high");
	enable_follow_a: assert property (
		wr && addr == 3'h1 |=> pins_to_port == $past(wdata[5])) else $error("pin owner wrong");
	irq_sticky_a: assert property (
		port_irq_flag && !wr |=> port_irq_flag) else $error("irq flag lost");
	start_cond_a: assert property (
		start_cmd_s |-> start_cond_s) else $error("no start condition");
	start_irq_a: assert property (
		start_cmd_s |-> ##[1:600] port_irq_flag) else $error("no irq after start");
	unmapped_zero_a: assert property (
		rd && addr > 3'h5 |=> rdata == 8'h00) else $error("unmapped read not zero");
endmodule // sspi2c_chk
bind sspi2c_core sspi2c_chk sspi2c_chk_i (.clk(clk), .arst_n(arst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe), .port_b_direction(port_b_direction),
	.port_irq_flag(port_irq_flag), .pins_to_port(pins_to_port));
`default_nettype wire

/* verif/sspi2c_slave_model.sv */
`default_nettype none
module sspi2c_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	output logic sda_oe_m
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// Far-side slave, acks each ninth bit while nack is low
	// ********
	int bits;
	initial begin
		bits = 0;
		sda_oe_m = 1'b0;
	end
	always @(negedge sda) begin
		if (scl)
			bits = 0;
	end
	always @(posedge scl) begin
		bits = (bits == 9) ? 1 : bits + 1;
	end
	always @(negedge scl) begin
		sda_oe_m = (bits == 8) && !nack;
	end
endmodule // sspi2c_slave_model
`default_nettype wire

/* verif/tb_sspi2c_core.sv */
`default_nettype none
module tb_sspi2c_core;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, arst_n, wr, rd, nack, prev;
	logic [2:0] addr;
	logic [7:0] wdata, rv;
	logic [1:0] dir;
	wire [7:0] rdata;
	wire scl_out, scl_oe, sda_out, sda_oe, irq, p2p, sda_oe_m, scl_w, sda_w;
	int error_cnt, total_checks, n, k, m;
	// Address, write data, expected read back; reload 2 gives a 12 clock bit
	logic [18:0] rows [8] = '{{3'h4, 8'h02, 8'h02}, {3'h5, 8'h00, 8'h00},
		{3'h1, 8'h2f, 8'h2f}, {3'h1, 8'h2e, 8'h2e}, {3'h1, 8'h2b, 8'h2b},
		{3'h1, 8'h27, 8'h27}, {3'h1, 8'h26, 8'h26}, {3'h1, 8'h28, 8'h28}};
	// ********
	// Bus with pull-ups
	// ********
	assign scl_w = scl_oe ? scl_out : 1'b1;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & !sda_oe_m;
	sspi2c_core sspi2c_core_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .port_b_direction(dir),
		.port_irq_flag(irq), .pins_to_port(p2p));
	sspi2c_slave_model sspi2c_slave_model_i (.scl(scl_w), .sda(sda_w), .nack(nack),
		.sda_oe_m(sda_oe_m));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	// Idle means no command bit pending and no transmit in progress
	task automatic wait_idle;
		for (n = 0; n < 400; n++) begin
			rreg(3'h2);
			if (rv[4:0] === 5'h00) begin
				rreg(3'h0);
				if (rv[2] === 1'b0)
					return;
			end
		end
		error_cnt++;
		$display("[ERR] %0t wait limit reached", $time);
		end_sim;
	endtask
	initial begin
		arst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		dir = 2'b11;
		nack = 1'b0;
		prev = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			if (i < 3 || i > 5) begin
				rreg(i[2:0]);
				chk(rv, 8'h00);
			end
		end
		foreach (rows[i]) begin
			wreg(rows[i][18:16], rows[i][15:8]);
			rreg(rows[i][18:16]);
			chk(rv, rows[i][7:0]);
		end
		chk({7'h0, p2p}, 8'h01);
		// ********
		// Master start; later command and buffer writes refused while it runs
		// ********
		wreg(3'h2, 8'h01);
		wreg(3'h2, 8'h04);
		wreg(3'h3, 8'h5a);
		wait_idle;
		rreg(3'h1);
		chk(rv, 8'ha8);
		rreg(3'h2);
		chk(rv, 8'h00);
		rreg(3'h5);
		chk(rv, 8'h01);
		chk({7'h0, irq}, 8'h01);
		wreg(3'h1, 8'h28);
		wreg(3'h5, 8'h00);
		wreg(3'h3, 8'ha4);
		rreg(3'h0);
		chk(rv & 8'h05, 8'h05);
		k = 0;
		m = 0;
		prev = scl_oe;
		for (n = 0; n < 200 && m < 2; n++) begin
			@(posedge clk);
			#1;
			if (scl_oe && !prev) begin
				m++;
				k = (m == 1) ? n : n - k;
			end
			prev = scl_oe;
		end
		chk(k[7:0], 8'h0c);
		wait_idle;
		rreg(3'h2);
		chk(rv & 8'h40, 8'h00);
		rreg(3'h0);
		chk(rv & 8'h01, 8'h00);
		nack = 1'b1;
		wreg(3'h3, 8'h5b);
		wait_idle;
		rreg(3'h2);
		chk(rv & 8'h40, 8'h40);
		// ********
		// Receive twice without reading
		// ********
		wreg(3'h2, 8'h08);
		wait_idle;
		wreg(3'h2, 8'h08);
		wait_idle;
		rreg(3'h1);
		chk(rv & 8'h40, 8'h40);
		rreg(3'h3);
		chk(rv, 8'hff);
		rreg(3'h0);
		chk(rv & 8'h01, 8'h00);
		wreg(3'h2, 8'h30);
		wait_idle;
		rreg(3'h2);
		chk(rv & 8'h3f, 8'h20);
		wreg(3'h2, 8'h04);
		wait_idle;
		chk({6'h0, scl_oe, sda_oe}, 8'h00);
		// Disable in mid-start must abort and free the lines
		wreg(3'h2, 8'h01);
		wreg(3'h1, 8'h08);
		rreg(3'h2);
		chk(rv & 8'h1f, 8'h00);
		chk({5'h0, p2p, scl_oe, sda_oe}, 8'h00);
		end_sim;
	end
endmodule // tb_sspi2c_core
`default_nettype wire
